//--- inc/phy_regs_pkg.sv
// Summary of operation
// - Interrupt register bit 11 enables link-partner-acknowledge interrupts, reset 0.
// - Interrupt register bit 10 enables link-down interrupts, reset 0.
// - Interrupt register bit 9 enables remote-fault interrupts, reset 0.
// - Interrupt register bit 8 enables link-up interrupts, reset 0.
// - Bits 15..12 enable jabber, receive error, page received, parallel-detect fault; reset 0.
// - Read-only sticky bit 7 flags a jabber event, reset 0.
// - Read-only sticky bit 6 flags a receive error, reset 0.
// - Read-only sticky bit 5 flags a received auto-negotiation page, reset 0.
// - Read-only sticky bit 4 flags a parallel-detection fault, reset 0.
// - Read-only sticky bit 3 flags a link partner acknowledge, reset 0.
// - Read-only sticky bit 2 flags link going down, reset 0.
// - Read-only sticky bit 1 flags a remote fault, reset 0.
// - Read-only sticky bit 0 flags link coming up, reset 0.
// - Writing 1 to diagnostic bit 15 starts the test; it self-clears on completion.
// - Results, including the 9-bit distance in bits 8:0, valid once bit 15 reads 0.
// - Bits 14:13 report outcome: 00 normal, 01 open, 10 short, 11 failed.
// - Bit 12 reports a cable shorter than 10 meters; reset 0.
`default_nettype none

package phy_regs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_INT_ADDR     = 5'h1B;
  localparam logic [4:0]  REG_DIAG_ADDR    = 5'h1D;

  // ----------------------------------------------------------------
  // Interrupt register fields
  // ----------------------------------------------------------------
  localparam int          INT_EN_LSB       = 8;
  localparam int          INT_FLAG_LSB     = 0;
  localparam logic [7:0]  INT_EN_RST       = 8'h00;
  localparam logic [7:0]  INT_FLAG_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Diagnostic register fields
  // ----------------------------------------------------------------
  localparam int          DIAG_START_BIT   = 15;
  localparam int          DIAG_RES_LSB     = 13;
  localparam int          DIAG_SHORT_BIT   = 12;
  localparam int          DIAG_RSVD_LSB    = 9;
  localparam int          DIAG_DIST_LSB    = 0;
  localparam logic [1:0]  DIAG_RES_NORMAL  = 2'h0;
  localparam logic [1:0]  DIAG_RES_OPEN    = 2'h1;
  localparam logic [1:0]  DIAG_RES_SHORT   = 2'h2;
  localparam logic [1:0]  DIAG_RES_FAIL    = 2'h3;
  localparam logic [2:0]  DIAG_RSVD_RST    = 3'h0;
  localparam logic [8:0]  DIAG_DIST_RST    = 9'h000;

  // ----------------------------------------------------------------
  // Management frame format
  // ----------------------------------------------------------------
  localparam logic [5:0]  PRE_ONES         = 6'h20;
  localparam logic [1:0]  OP_READ          = 2'h2;
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [3:0]  HDR_LAST_BIT     = 4'hB;
  localparam logic [3:0]  TA_LAST_BIT      = 4'h1;
  localparam logic [3:0]  DATA_LAST_BIT    = 4'hF;

endpackage

`default_nettype wire

//--- rtl/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // First stage feeds only the second; the filter looks at stages two and three
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      pin_out <= '0;
    end else begin
      s1_r    <= pin_in;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_out[i] <= s3_r[i];  // Change counts only once both agree
        end
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

//--- rtl/phy_irq_diag_regs.sv
`timescale 1ns/1ps
`default_nettype none

module phy_irq_diag_regs #(
  parameter logic [5:0] PRE_ONES = phy_regs_pkg::PRE_ONES
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  input  wire logic [4:0] phy_addr,
  input  wire logic       jabber_evt,
  input  wire logic       rx_err_evt,
  input  wire logic       page_rx_evt,
  input  wire logic       pd_fault_evt,
  input  wire logic       lp_ack_evt,
  input  wire logic       link_down_evt,
  input  wire logic       remote_fault_evt,
  input  wire logic       link_up_evt,
  input  wire logic       diag_done,
  input  wire logic [1:0] diag_result,
  input  wire logic       diag_short,
  input  wire logic [8:0] diag_distance,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  output logic            int_req,
  output logic            diag_start
);

  // ----------------------------------------------------------------
  // Types and signals
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA
  } frame_state_t;

  frame_state_t state_r;
  logic [1:0]   pin_sync;
  logic         mdc_s;
  logic         mdio_s;
  logic         mdc_q_r;
  logic         mdc_rise;
  logic [5:0]   pre_cnt_r;
  logic [3:0]   bit_cnt_r;
  logic [10:0]  hdr_r;
  logic [11:0]  hdr_full;
  logic [15:0]  wr_shift_r;
  logic [15:0]  wr_data;
  logic [15:0]  rd_shift_r;
  logic [15:0]  rd_value;
  logic         sel_rd_r;
  logic         sel_wr_r;
  logic [4:0]   reg_sel_r;
  logic         hdr_done;
  logic         data_done;
  logic         hdr_rd;
  logic         hdr_wr;
  logic         wr_int;
  logic         wr_diag;
  logic         rd_int_clr;
  logic [4:0]   phy_addr_r;
  logic         addr_taken_r;
  logic [7:0]   int_en_r;
  logic [7:0]   int_flag_r;
  logic [7:0]   evt_vec;
  logic         diag_busy_r;
  logic [1:0]   diag_res_r;
  logic         diag_short_r;
  logic [2:0]   diag_rsvd_r;
  logic [8:0]   diag_dist_r;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock edge detect
  // ----------------------------------------------------------------
  pin_sync3 #(
    .WIDTH (2)
  ) u_pin_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .pin_in  ({mdc, mdio_in}),
    .pin_out (pin_sync)
  );

  assign mdc_s  = pin_sync[1];
  assign mdio_s = pin_sync[0];

  // Both pins share one synchroniser delay, so data sampled at the edge is aligned
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_q_r;

  // Strap address caught once after reset release, not under the reset itself
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phy_addr_r   <= 5'h00;
      addr_taken_r <= 1'b0;
    end else if (!addr_taken_r) begin
      phy_addr_r   <= phy_addr;
      addr_taken_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  assign hdr_full  = {hdr_r, mdio_s};
  assign hdr_done  = mdc_rise && (state_r == ST_HDR) && (bit_cnt_r == phy_regs_pkg::HDR_LAST_BIT);
  assign data_done = mdc_rise && (state_r == ST_DATA) && (bit_cnt_r == phy_regs_pkg::DATA_LAST_BIT);
  assign wr_data   = {wr_shift_r[14:0], mdio_s};

  // Only the two registers of this block answer; other addresses stay undriven
  always_comb begin
    hdr_rd = 1'b0;
    hdr_wr = 1'b0;
    if (addr_taken_r && (hdr_full[9:5] == phy_addr_r) &&
        ((hdr_full[4:0] == phy_regs_pkg::REG_INT_ADDR) ||
         (hdr_full[4:0] == phy_regs_pkg::REG_DIAG_ADDR))) begin
      hdr_rd = (hdr_full[11:10] == phy_regs_pkg::OP_READ);
      hdr_wr = (hdr_full[11:10] == phy_regs_pkg::OP_WRITE);
    end
  end

  assign wr_int     = data_done && sel_wr_r && (reg_sel_r == phy_regs_pkg::REG_INT_ADDR);
  assign wr_diag    = data_done && sel_wr_r && (reg_sel_r == phy_regs_pkg::REG_DIAG_ADDR);
  assign rd_int_clr = hdr_done && hdr_rd && (hdr_full[4:0] == phy_regs_pkg::REG_INT_ADDR);

  // Frame sequencer; a full preamble is required before every frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      pre_cnt_r <= 6'h00;
      bit_cnt_r <= 4'h0;
      hdr_r     <= 11'h000;
      sel_rd_r  <= 1'b0;
      sel_wr_r  <= 1'b0;
      reg_sel_r <= 5'h00;
    end else if (mdc_rise) begin
      case (state_r)
        ST_IDLE: begin
          if (mdio_s) begin
            if (pre_cnt_r < PRE_ONES) begin
              pre_cnt_r <= pre_cnt_r + 6'h01;
            end
          end else begin
            if (pre_cnt_r >= PRE_ONES) begin
              state_r <= ST_START;
            end
            pre_cnt_r <= 6'h00;
          end
        end
        ST_START: begin
          bit_cnt_r <= 4'h0;
          state_r   <= mdio_s ? ST_HDR : ST_IDLE;
        end
        ST_HDR: begin
          hdr_r     <= hdr_full[10:0];
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == phy_regs_pkg::HDR_LAST_BIT) begin
            state_r   <= ST_TA;
            bit_cnt_r <= 4'h0;
            sel_rd_r  <= hdr_rd;
            sel_wr_r  <= hdr_wr;
            reg_sel_r <= hdr_full[4:0];
          end
        end
        ST_TA: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == phy_regs_pkg::TA_LAST_BIT) begin
            state_r   <= ST_DATA;
            bit_cnt_r <= 4'h0;
          end
        end
        ST_DATA: begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == phy_regs_pkg::DATA_LAST_BIT) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            sel_rd_r  <= 1'b0;
            sel_wr_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Write data collector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_shift_r <= 16'h0000;
    end else if (mdc_rise && (state_r == ST_DATA)) begin
      wr_shift_r <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // Register images; reserved diagnostic bits read back as written
  always_comb begin
    rd_value = 16'h0000;
    if (hdr_full[4:0] == phy_regs_pkg::REG_INT_ADDR) begin
      rd_value[phy_regs_pkg::INT_EN_LSB +: 8]   = int_en_r;
      rd_value[phy_regs_pkg::INT_FLAG_LSB +: 8] = int_flag_r;
    end else begin
      rd_value[phy_regs_pkg::DIAG_START_BIT]    = diag_busy_r;
      rd_value[phy_regs_pkg::DIAG_RES_LSB +: 2] = diag_res_r;
      rd_value[phy_regs_pkg::DIAG_SHORT_BIT]    = diag_short_r;
      rd_value[phy_regs_pkg::DIAG_RSVD_LSB +: 3] = diag_rsvd_r;
      rd_value[phy_regs_pkg::DIAG_DIST_LSB +: 9] = diag_dist_r;
    end
  end

  // Drive after each rising edge so the master samples stable data on the next one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_shift_r <= 16'h0000;
      mdio_out   <= 1'b0;
      mdio_oe_n  <= 1'b1;
    end else if (mdc_rise) begin
      if (hdr_done && hdr_rd) begin
        rd_shift_r <= rd_value;  // Snapshot taken before the flags clear
      end else if (sel_rd_r && (state_r == ST_TA) && (bit_cnt_r == 4'h0)) begin
        mdio_oe_n <= 1'b0;
        mdio_out  <= 1'b0;
      end else if (sel_rd_r && ((state_r == ST_TA) ||
                                ((state_r == ST_DATA) && (bit_cnt_r != phy_regs_pkg::DATA_LAST_BIT)))) begin
        mdio_out   <= rd_shift_r[15];
        rd_shift_r <= {rd_shift_r[14:0], 1'b0};
      end else begin
        mdio_oe_n <= 1'b1;
        mdio_out  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control and status
  // ----------------------------------------------------------------
  assign evt_vec = {jabber_evt, rx_err_evt, page_rx_evt, pd_fault_evt,
                    lp_ack_evt, link_down_evt, remote_fault_evt, link_up_evt};

  // Enables; upper nibble covers jabber, rx error, page, parallel-detect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_en_r <= phy_regs_pkg::INT_EN_RST;
    end else if (wr_int) begin
      int_en_r[7:4] <= wr_data[15:12];
      int_en_r[3]   <= wr_data[11];
      int_en_r[2]   <= wr_data[10];
      int_en_r[1]   <= wr_data[9];
      int_en_r[0]   <= wr_data[8];
    end
  end

  // Sticky flags: an event in the clearing cycle wins, so nothing is lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_flag_r <= phy_regs_pkg::INT_FLAG_RST;
    end else begin
      int_flag_r[7] <= (int_flag_r[7] & ~rd_int_clr) | evt_vec[7];
      int_flag_r[6] <= (int_flag_r[6] & ~rd_int_clr) | evt_vec[6];
      int_flag_r[5] <= (int_flag_r[5] & ~rd_int_clr) | evt_vec[5];
      int_flag_r[4] <= (int_flag_r[4] & ~rd_int_clr) | evt_vec[4];
      int_flag_r[3] <= (int_flag_r[3] & ~rd_int_clr) | evt_vec[3];
      int_flag_r[2] <= (int_flag_r[2] & ~rd_int_clr) | evt_vec[2];
      int_flag_r[1] <= (int_flag_r[1] & ~rd_int_clr) | evt_vec[1];
      int_flag_r[0] <= (int_flag_r[0] & ~rd_int_clr) | evt_vec[0];
    end
  end

  // Registered request; lags the flag by one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_req <= 1'b0;
    end else begin
      int_req <= |(int_flag_r & int_en_r);
    end
  end

  // ----------------------------------------------------------------
  // Cable diagnostic control and status
  // ----------------------------------------------------------------
  // A start while a test runs is ignored; the test cannot be aborted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_busy_r <= 1'b0;
      diag_start  <= 1'b0;
    end else begin
      diag_start <= 1'b0;
      if (diag_busy_r && diag_done) begin
        diag_busy_r <= 1'b0;
      end else if (wr_diag && wr_data[phy_regs_pkg::DIAG_START_BIT] && !diag_busy_r) begin
        diag_busy_r <= 1'b1;
        diag_start  <= 1'b1;
      end
    end
  end

  // Results change only at completion, so they are stable once the start bit drops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_res_r   <= phy_regs_pkg::DIAG_RES_NORMAL;
      diag_short_r <= 1'b0;
      diag_dist_r  <= phy_regs_pkg::DIAG_DIST_RST;
    end else if (diag_busy_r && diag_done) begin
      diag_res_r   <= diag_result;
      diag_short_r <= diag_short;
      diag_dist_r  <= diag_distance;
    end
  end

  // Reserved read-write bits of the diagnostic register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_rsvd_r <= phy_regs_pkg::DIAG_RSVD_RST;
    end else if (wr_diag) begin
      diag_rsvd_r <= wr_data[phy_regs_pkg::DIAG_RSVD_LSB +: 3];
    end
  end

endmodule // phy_irq_diag_regs

`default_nettype wire

//--- verification/phy_irq_diag_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module phy_irq_diag_regs_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic jabber_evt,
  input wire logic rx_err_evt,
  input wire logic page_rx_evt,
  input wire logic pd_fault_evt,
  input wire logic lp_ack_evt,
  input wire logic link_down_evt,
  input wire logic remote_fault_evt,
  input wire logic link_up_evt,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic int_req,
  input wire logic diag_start
);
  logic [7:0] evts;
  logic       mdc_q_r;
  logic [4:0] rise_cnt_r;

  assign evts = {jabber_evt, rx_err_evt, page_rx_evt, pd_fault_evt,
                 lp_ack_evt, link_down_evt, remote_fault_evt, link_up_evt};

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // MDC pin rises seen while the device drives; a read answer spans 17
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q_r    <= 1'b0;
      rise_cnt_r <= 5'h00;
    end else begin
      mdc_q_r <= mdc;
      if (mdio_oe_n) begin
        rise_cnt_r <= 5'h00;
      end else if (mdc && !mdc_q_r) begin
        rise_cnt_r <= rise_cnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_reset_quiet: assert property ($rose(rst_n) |-> mdio_oe_n && !mdio_out && !int_req && !diag_start)
    else $error("outputs not quiet after reset");
  chk_idle_low: assert property (mdio_oe_n |-> !mdio_out)
    else $error("data out high while not driving");
  chk_drive_start: assert property ($fell(mdio_oe_n) |-> mdc && $past(mdc, 3) && !mdio_out)
    else $error("drive begins off an MDC rise or not with a zero");
  chk_bit_on_rise: assert property (!mdio_oe_n && $changed(mdio_out) |-> mdc && $past(mdc, 3))
    else $error("read bit changed away from an MDC rise");
  chk_drive_span: assert property ($rose(mdio_oe_n) |-> mdc && rise_cnt_r == 5'h11)
    else $error("read answer did not span 17 MDC rises");
  chk_start_pulse: assert property (diag_start |=> !diag_start [*8])
    else $error("test launch pulse longer than one cycle");
  chk_start_quiet: assert property (diag_start |-> mdio_oe_n)
    else $error("test launched during a read answer");
  chk_int_cause: assert property ($rose(int_req) |-> $past(|evts, 2) || $past(mdc, 2))
    else $error("interrupt rose with no event and no write");

endmodule // phy_irq_diag_regs_props

`default_nettype wire

//--- verification/mdio_mgmt_model.sv
`timescale 1ns/1ps
`default_nettype none

module mdio_mgmt_model (
  input  wire logic mclk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_n,
  output logic      mdc,
  output wire logic mdio_in
);
  logic m_oe_n;
  logic bit_v;

  // Wire level: device when it drives, else master, else the pull-up
  assign mdio_in = !mdio_oe_n ? mdio_out : (!m_oe_n ? bit_v : 1'b1);

  // MDC stands low and the line is released outside frames
  initial begin
    mdc    = 1'b0;
    m_oe_n = 1'b1;
    bit_v  = 1'b1;
  end

  // One MDC period; data changes at the fall, both sides sample at the rise
  task automatic clk_bit(input logic d, input logic drive, output logic s);
    m_oe_n = !drive;
    bit_v  = d;
    mdc    = 1'b0;
    repeat (8) @(negedge mclk);
    mdc = 1'b1;
    s   = mdio_in;
    repeat (8) @(negedge mclk);
  endtask

  // Whole frame; a short preamble count lets a bench build a bad frame
  task automatic frame(input int npre, input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic        s;
    hdr  = {2'b01, op, pa, ra};
    tail = {2'b10, wd};
    rd   = 16'h0000;
    for (int i = 0; i < npre; i++) clk_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
    // Master lets go of the line from turnaround on when reading
    for (int i = 17; i >= 0; i--) begin
      clk_bit(tail[i], op == phy_regs_pkg::OP_WRITE, s);
      if (i < 16) rd[i] = s;
    end
    mdc    = 1'b0;
    m_oe_n = 1'b1;
    // Let an edge pass so the next frame never re-drives the line in this time step
    @(negedge mclk);
  endtask

endmodule // mdio_mgmt_model

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module tb;
  localparam int         NPRE    = 8;
  localparam logic [4:0] MY_ADDR = 5'h03;
  localparam logic [4:0] INT_A   = phy_regs_pkg::REG_INT_ADDR;
  localparam logic [4:0] DIAG_A  = phy_regs_pkg::REG_DIAG_ADDR;

  logic        mclk, rst_n, mdio_out, mdio_oe_n, int_req, diag_start;
  logic        diag_done, diag_short;
  logic [7:0]  evt;
  logic [1:0]  diag_result;
  logic [8:0]  diag_distance;
  logic [15:0] rdata, last;
  wire         mdc, mdio_in;
  int          fails, check_count, start_seen;

  phy_irq_diag_regs #(.PRE_ONES(NPRE[5:0])) i_dut (
    .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .phy_addr(MY_ADDR),
    .jabber_evt(evt[7]), .rx_err_evt(evt[6]), .page_rx_evt(evt[5]), .pd_fault_evt(evt[4]),
    .lp_ack_evt(evt[3]), .link_down_evt(evt[2]), .remote_fault_evt(evt[1]), .link_up_evt(evt[0]),
    .diag_done(diag_done), .diag_result(diag_result), .diag_short(diag_short),
    .diag_distance(diag_distance), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .int_req(int_req), .diag_start(diag_start));

  mdio_mgmt_model i_mgmt (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
    .mdio_in(mdio_in));

  // ----------------------------------------------------------------
  // Clock, launch monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Launch pulses come and go inside a write, so they are counted here
  always @(posedge mclk) if (diag_start === 1'b1) start_seen++;

  // About 30k cycles of frames are expected
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
    i_mgmt.frame(NPRE, phy_regs_pkg::OP_READ, pa, ra, 16'h0000, rdata);
    `CHK(rdata, exp)
  endtask

  task automatic wr(input int np, input logic [4:0] ra, input logic [15:0] d);
    i_mgmt.frame(np, phy_regs_pkg::OP_WRITE, MY_ADDR, ra, d, rdata);
  endtask

  task automatic pulse(input logic [7:0] v);
    evt = v;
    @(negedge mclk);
    evt = 8'h00;
    repeat (3) @(negedge mclk);
  endtask

  task automatic print_verdict();
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; evt = 8'h00; diag_done = 1'b0; diag_result = 2'h0; diag_short = 1'b0;
    diag_distance = 9'h000; fails = 0; check_count = 0; start_seen = 0; last = 16'h0000;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    rd_chk(MY_ADDR, INT_A, 16'h0000);
    rd_chk(MY_ADDR, DIAG_A, 16'h0000);
    wr(NPRE, INT_A, 16'hFFFF);
    rd_chk(MY_ADDR, INT_A, 16'hFF00);
    // One enable at a time: the others' events must not interrupt
    for (int i = 0; i < 8; i++) begin
      wr(NPRE, INT_A, 16'h0100 << i);
      pulse(~(8'h01 << i));
      `CHK(int_req, 1'b0)
      pulse(8'h01 << i);
      `CHK(int_req, 1'b1)
      rd_chk(MY_ADDR, INT_A, (16'h0100 << i) | 16'h00FF);
      `CHK(int_req, 1'b0)
    end
    // An event still present while the read clears must stay pending
    evt[0] = 1'b1;
    rd_chk(MY_ADDR, INT_A, 16'h8001);
    evt[0] = 1'b0;
    rd_chk(MY_ADDR, INT_A, 16'h8001);
    // Foreign address and unmapped register float and leave flags alone
    pulse(8'h80);
    rd_chk(5'h04, INT_A, 16'hFFFF);
    rd_chk(MY_ADDR, 5'h1C, 16'hFFFF);
    // An unknown op code is not answered and does not clear the flags
    i_mgmt.frame(NPRE, 2'h3, MY_ADDR, INT_A, 16'h0000, rdata);
    `CHK(rdata, 16'hFFFF)
    `CHK(int_req, 1'b1)
    rd_chk(MY_ADDR, INT_A, 16'h8080);
    // A write with one preamble bit short, or with a bad op code, is ignored
    i_mgmt.frame(NPRE, 2'h0, MY_ADDR, INT_A, 16'h0000, rdata);
    wr(NPRE - 1, INT_A, 16'h0000);
    rd_chk(MY_ADDR, INT_A, 16'h8000);
    // Every result code; results stay old until the test finishes
    for (int k = 0; k < 4; k++) begin
      wr(NPRE, DIAG_A, 16'h8A00);
      `CHK(start_seen, k + 1)
      rd_chk(MY_ADDR, DIAG_A, 16'h8A00 | last);
      wr(NPRE, DIAG_A, 16'h8A00);
      `CHK(start_seen, k + 1)
      diag_result = k[1:0];
      diag_short = k[0];
      diag_distance = 9'h1FF >> k;
      diag_done = 1'b1;
      @(negedge mclk);
      diag_done = 1'b0;
      last = {1'b0, diag_result, diag_short, 3'b000, diag_distance};
      rd_chk(MY_ADDR, DIAG_A, 16'h0A00 | last);
    end
    // A completion outside a test changes nothing
    diag_result = 2'h1;
    diag_distance = 9'h055;
    diag_done = 1'b1;
    @(negedge mclk);
    diag_done = 1'b0;
    rd_chk(MY_ADDR, DIAG_A, 16'h0A00 | last);
    // A reset in mid-run returns both registers to their reset values
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    rd_chk(MY_ADDR, INT_A, 16'h0000);
    rd_chk(MY_ADDR, DIAG_A, 16'h0000);
    print_verdict();
  end

endmodule // tb

bind phy_irq_diag_regs phy_irq_diag_regs_props i_props (
  .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .jabber_evt(jabber_evt), .rx_err_evt(rx_err_evt),
  .page_rx_evt(page_rx_evt), .pd_fault_evt(pd_fault_evt), .lp_ack_evt(lp_ack_evt),
  .link_down_evt(link_down_evt), .remote_fault_evt(remote_fault_evt), .link_up_evt(link_up_evt),
  .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .int_req(int_req), .diag_start(diag_start));

`default_nettype wire
